// >>> core/ea_gen_pkg.sv
// Constants, modes and carriers for the effective address generator
package ea_gen_pkg;

  localparam int ADDR_W     = 24;
  localparam int REG_W      = 32;
  localparam int SHORT_W    = 20;
  localparam int BITNUM_W   = 3;
  localparam int VECSEL_W   = 2;

  localparam logic [15:0] SHORT_ABS_FILL = 16'hFFFF;
  localparam logic [3:0]  MB1_MASK_HI    = 4'h0;
  localparam logic [31:0] STEP_BYTE      = 32'h00000001;
  localparam logic [31:0] STEP_WORD      = 32'h00000002;
  localparam logic [31:0] STEP_LONG      = 32'h00000004;

  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_WORD = 2'h1,
    SIZE_LONG = 2'h2
  } access_size_t;

  typedef enum logic [3:0] {
    MODE_REG_INDIRECT = 4'h0,
    MODE_DISP16       = 4'h1,
    MODE_POST_INC     = 4'h2,
    MODE_PRE_DEC      = 4'h3,
    MODE_ABS8         = 4'h4,
    MODE_ABS16        = 4'h5,
    MODE_ABS24        = 4'h6,
    MODE_IMM8         = 4'h7,
    MODE_IMM16        = 4'h8,
    MODE_IMM32        = 4'h9,
    MODE_PC_REL8      = 4'hA,
    MODE_PC_REL16     = 4'hB,
    MODE_MEM_INDIRECT = 4'hC,
    MODE_IMPLICIT     = 4'hD,
    MODE_BIT_NUMBER   = 4'hE,
    MODE_TRAP         = 4'hF
  } addr_mode_t;

  // Implicit constant kinds for small add/sub and inc/dec
  typedef enum logic [2:0] {
    IMPL_ONE   = 3'h0,
    IMPL_TWO   = 3'h1,
    IMPL_FOUR  = 3'h2,
    IMPL_M_ONE = 3'h3,
    IMPL_M_TWO = 3'h4,
    IMPL_M_FOUR= 3'h5
  } implicit_t;

  typedef struct packed {
    logic         valid;
    addr_mode_t   mode;
    access_size_t size;
    logic [31:0]  ext;
    logic [23:0]  next_pc;
    logic [2:0]   op_field;
    logic         branch;
  } ea_req_t;

  typedef struct packed {
    logic        valid;
    logic [23:0] addr;
    logic        addr_valid;
    logic [31:0] operand;
    logic        operand_valid;
    logic        wb_en;
    logic [31:0] wb_value;
    logic        ptr_fetch;
  } ea_resp_t;

endpackage

// >>> core/ea_step_unit.sv
// Access size step and register update arithmetic
`timescale 1ns/1ns
module ea_step_unit
  import ea_gen_pkg::*;
(
  input  wire logic [31:0]  reg_value,
  input  wire access_size_t size,
  input  wire logic         decrement,
  output logic [31:0]       result
);

  logic [31:0] step;

  always_comb begin
    unique case (size)
      SIZE_BYTE: step = STEP_BYTE;
      SIZE_WORD: step = STEP_WORD;
      SIZE_LONG: step = STEP_LONG;
      default:   step = STEP_BYTE;
    endcase
    // Full 32-bit arithmetic, upper byte carries too
    result = decrement ? reg_value - step : reg_value + step;
  end

endmodule

// >>> core/effective_address_generator.sv
// Effective address generator top level
`timescale 1ns/1ns
// What this block does
// - Post-increment: use register, then add size
// - Post-increment step is 1, 2 or 4
// - Pre-decrement: subtract size, write back, use result
// - Pre-decrement step is 1, 2 or 4
// - Short absolute: upper sixteen bits all ones
// - Sixteen-bit absolute is sign-extended
// - Full absolute address used unchanged
// - One-megabyte modes drop top four bits
// - Immediate taken from 8/16/32-bit code data
// - Small add/sub, inc/dec constants from opcode
// - Bit number from three-bit code field
// - Trap vector from two-bit code field
// - Branch displacement sign-extended, added to PC
// - PC is address after branch instruction
// - Memory-indirect pointer zero-extended, below 256
// - Pointer fetched as longword, first byte dropped
// - Odd word, long or branch address made even
// - Plain indirect uses low register bits
// - Displacement sign-extended, low bits of sum
module effective_address_generator
  import ea_gen_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire ea_req_t     req,
  input  wire logic [31:0] address_register,
  input  wire logic        mode_1mbyte,
  input  wire logic        ptr_data_valid,
  input  wire logic [31:0] ptr_data,
  output ea_resp_t         resp,
  output logic [23:0]      branch_target,
  output logic             branch_target_valid
);

  // ********************************************************
  // Helpers
  // ********************************************************
  function automatic logic [23:0] fit_space(input logic [23:0] a, input logic mb1);
    fit_space = mb1 ? {MB1_MASK_HI, a[SHORT_W-1:0]} : a;
  endfunction

  function automatic logic [23:0] force_even(input logic [23:0] a, input logic even);
    force_even = even ? {a[23:1], 1'b0} : a;
  endfunction

  function automatic logic [23:0] sext8_addr(input logic [7:0] d);
    sext8_addr = {{16{d[7]}}, d};
  endfunction

  function automatic logic [23:0] sext16_addr(input logic [15:0] d);
    sext16_addr = {{8{d[15]}}, d};
  endfunction

  function automatic logic [31:0] implicit_value(input logic [2:0] code);
    unique case (code)
      IMPL_ONE:    implicit_value = 32'h00000001;
      IMPL_TWO:    implicit_value = 32'h00000002;
      IMPL_FOUR:   implicit_value = 32'h00000004;
      IMPL_M_ONE:  implicit_value = 32'hFFFFFFFF;
      IMPL_M_TWO:  implicit_value = 32'hFFFFFFFE;
      IMPL_M_FOUR: implicit_value = 32'hFFFFFFFC;
      default:     implicit_value = 32'h00000000;
    endcase
  endfunction

  // ********************************************************
  // Pointer fetch sequencer
  // ********************************************************
  typedef enum logic [1:0] {
    PTR_IDLE = 2'b01,
    PTR_WAIT = 2'b10
  } ptr_state_t;

  ptr_state_t state;
  ptr_state_t next_state;
  logic [23:0] branch_target_q;
  logic [23:0] next_branch_target;
  logic        target_valid_q;
  logic        next_target_valid;
  logic [31:0] stepped;
  logic        step_down;
  ea_resp_t    comb_resp;
  logic        wide;

  ea_step_unit u_step (
    .reg_value (address_register),
    .size      (req.size),
    .decrement (step_down),
    .result    (stepped)
  );

  // Kept outside the decode process so the stepped value feeds it without a loop
  assign step_down = (req.mode == MODE_PRE_DEC);

  // ********************************************************
  // Address formation, same cycle as decode
  // ********************************************************
  always_comb begin
    logic [23:0] a;
    a = 24'h000000;
    wide = (req.size != SIZE_BYTE) | req.branch;
    comb_resp = '0;
    comb_resp.valid = req.valid;
    unique case (req.mode)
      MODE_REG_INDIRECT: begin
        a = address_register[ADDR_W-1:0];
        comb_resp.addr_valid = 1'b1;
      end
      MODE_DISP16: begin
        a = address_register[ADDR_W-1:0] + sext16_addr(req.ext[15:0]);
        comb_resp.addr_valid = 1'b1;
      end
      MODE_POST_INC: begin
        a = address_register[ADDR_W-1:0];
        comb_resp.addr_valid = 1'b1;
        comb_resp.wb_en = 1'b1;
        comb_resp.wb_value = stepped;
      end
      MODE_PRE_DEC: begin
        a = stepped[ADDR_W-1:0];
        comb_resp.addr_valid = 1'b1;
        comb_resp.wb_en = 1'b1;
        comb_resp.wb_value = stepped;
      end
      MODE_ABS8: begin
        a = {SHORT_ABS_FILL, req.ext[7:0]};
        comb_resp.addr_valid = 1'b1;
      end
      MODE_ABS16: begin
        a = sext16_addr(req.ext[15:0]);
        comb_resp.addr_valid = 1'b1;
      end
      MODE_ABS24: begin
        a = req.ext[ADDR_W-1:0];
        comb_resp.addr_valid = 1'b1;
      end
      MODE_IMM8: begin
        comb_resp.operand = {24'h000000, req.ext[7:0]};
        comb_resp.operand_valid = 1'b1;
      end
      MODE_IMM16: begin
        comb_resp.operand = {16'h0000, req.ext[15:0]};
        comb_resp.operand_valid = 1'b1;
      end
      MODE_IMM32: begin
        comb_resp.operand = req.ext;
        comb_resp.operand_valid = 1'b1;
      end
      MODE_PC_REL8: begin
        a = req.next_pc + sext8_addr(req.ext[7:0]);
        comb_resp.addr_valid = 1'b1;
      end
      MODE_PC_REL16: begin
        a = req.next_pc + sext16_addr(req.ext[15:0]);
        comb_resp.addr_valid = 1'b1;
      end
      MODE_MEM_INDIRECT: begin
        a = {16'h0000, req.ext[7:0]};
        comb_resp.addr_valid = 1'b1;
        comb_resp.ptr_fetch = 1'b1;
        wide = 1'b1;                // Pointer is a longword
      end
      MODE_IMPLICIT: begin
        comb_resp.operand = implicit_value(req.op_field);
        comb_resp.operand_valid = 1'b1;
      end
      MODE_BIT_NUMBER: begin
        comb_resp.operand = {29'h00000000, req.op_field[BITNUM_W-1:0]};
        comb_resp.operand_valid = 1'b1;
      end
      MODE_TRAP: begin
        comb_resp.operand = {30'h00000000, req.op_field[VECSEL_W-1:0]};
        comb_resp.operand_valid = 1'b1;
      end
      default: begin
        a = 24'h000000;
      end
    endcase
    // Odd registers are software's fault; hardware only aligns
    comb_resp.addr = fit_space(force_even(a, wide), mode_1mbyte);
    if (!req.valid) begin
      comb_resp = '0;
    end
  end

  assign resp = comb_resp;

  // ********************************************************
  // Pointer longword return to branch target
  // ********************************************************
  always_comb begin
    next_state = state;
    next_branch_target = branch_target_q;
    next_target_valid = 1'b0;
    unique case (state)
      PTR_IDLE: begin
        if (comb_resp.ptr_fetch) begin
          next_state = PTR_WAIT;
        end
      end
      PTR_WAIT: begin
        if (ptr_data_valid) begin
          // First byte dropped, then aligned and fitted
          next_branch_target = fit_space(force_even(ptr_data[ADDR_W-1:0], 1'b1), mode_1mbyte);
          next_target_valid = 1'b1;
          next_state = PTR_IDLE;
        end
      end
      default: begin
        next_state = PTR_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= PTR_IDLE;
      branch_target_q <= 24'h000000;
      target_valid_q <= 1'b0;
    end else begin
      state <= next_state;
      branch_target_q <= next_branch_target;
      target_valid_q <= next_target_valid;
    end
  end

  assign branch_target = branch_target_q;
  assign branch_target_valid = target_valid_q;

endmodule

// >>> tb/ea_gen_sva.sv
// Assertion checker for the effective address generator
`timescale 1ns/1ns
module ea_gen_sva
  import ea_gen_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire ea_req_t     req,
  input wire logic [31:0] address_register,
  input wire logic        mode_1mbyte,
  input wire logic        ptr_data_valid,
  input wire logic [31:0] ptr_data,
  input wire ea_resp_t    resp,
  input wire logic [23:0] branch_target,
  input wire logic        branch_target_valid
);
  // ****************************************
  // Helpers and properties
  // ****************************************
  logic [31:0] step;
  logic [23:0] ptr_even;
  logic        full;
  assign step = (req.size == SIZE_BYTE) ? STEP_BYTE : (req.size == SIZE_WORD) ? STEP_WORD : STEP_LONG;
  assign ptr_even = {ptr_data[23:1], 1'b0};
  assign full = req.valid & ~mode_1mbyte;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_post_inc;
    req.valid && req.mode == MODE_POST_INC |-> resp.wb_en && resp.wb_value == address_register + step;
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("post increment wrong");
  property p_pre_dec;
    full && req.mode == MODE_PRE_DEC |->
      resp.wb_value == address_register - step && resp.addr[23:1] == resp.wb_value[23:1] &&
      (req.size != SIZE_BYTE || resp.addr[0] == resp.wb_value[0]);
  endproperty
  a_pre_dec: assert property (p_pre_dec) else $error("pre decrement wrong");
  property p_abs8;
    full && req.mode == MODE_ABS8 && req.size == SIZE_BYTE |-> resp.addr == {SHORT_ABS_FILL, req.ext[7:0]};
  endproperty
  a_abs8: assert property (p_abs8) else $error("short absolute fill wrong");
  property p_even;
    req.valid && req.size != SIZE_BYTE && resp.addr_valid |-> !resp.addr[0];
  endproperty
  a_even: assert property (p_even) else $error("odd address not forced even");
  property p_trunc;
    req.valid && mode_1mbyte && resp.addr_valid |-> resp.addr[23:20] == MB1_MASK_HI;
  endproperty
  a_trunc: assert property (p_trunc) else $error("upper address bits kept");
  property p_ptr_fetch;
    req.valid && req.mode == MODE_MEM_INDIRECT |-> resp.ptr_fetch && resp.addr[23:8] == 16'h0;
  endproperty
  a_ptr_fetch: assert property (p_ptr_fetch) else $error("pointer fetch wrong");
  property p_target;
    branch_target_valid && !mode_1mbyte |-> $past(ptr_data_valid) && branch_target == $past(ptr_even);
  endproperty
  a_target: assert property (p_target) else $error("branch target wrong");
  property p_pulse;
    branch_target_valid |=> !branch_target_valid;
  endproperty
  a_pulse: assert property (p_pulse) else $error("target valid too long");
  c_post: cover property (req.valid && req.mode == MODE_POST_INC);
  c_mem: cover property (resp.ptr_fetch);
  c_target: cover property (branch_target_valid);
endmodule

// >>> tb/ptr_bus_model.sv
// Bus unit model answering memory-indirect pointer fetches
`timescale 1ns/1ns
module ptr_bus_model (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        fetch,
  input  wire logic        slow,
  input  wire logic [31:0] value,
  output logic             data_valid,
  output logic [31:0]      data
);
  logic [3:0] wait_cnt;
  logic       busy;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      wait_cnt <= 4'h0;
      data_valid <= 1'b0;
      data <= 32'h5A5A5A5A;
    end else begin
      data_valid <= 1'b0;
      // Idle bus never holds the last value
      data <= ~data;
      if (fetch && !busy) begin
        busy <= 1'b1;
        wait_cnt <= slow ? 4'h5 : 4'h0;
      end else if (busy && wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end else if (busy) begin
        busy <= 1'b0;
        data_valid <= 1'b1;
        data <= value;
      end
    end
  end
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the effective address generator
`timescale 1ns/1ns
module tb_top;
  import ea_gen_pkg::*;
  typedef struct packed {
    addr_mode_t m; access_size_t s; logic [31:0] e; logic [31:0] a; logic [31:0] x; logic [31:0] w;
  } row_t;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  ea_req_t     req = '0;
  logic [31:0] address_register = 32'h0;
  logic        mode_1mbyte = 1'b0;
  logic        slow = 1'b0;
  logic [31:0] ptr_value = 32'hAA123457;
  logic        is_op;
  logic        is_wb;
  logic        ptr_data_valid;
  logic [31:0] ptr_data;
  ea_resp_t    resp;
  logic [23:0] branch_target;
  logic        branch_target_valid;
  int          n_errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  // ****************************************
  // Table cases: mode, size, ext, register or pc, expected, write-back
  // ****************************************
  row_t rows [18] = '{
    '{MODE_POST_INC, SIZE_LONG, 32'h0, 32'h12FFFFFC, 32'hFFFFFC, 32'h13000000},
    '{MODE_POST_INC, SIZE_WORD, 32'h0, 32'h1000, 32'h1000, 32'h1002},
    '{MODE_PRE_DEC, SIZE_WORD, 32'h0, 32'h2000, 32'h1FFE, 32'h1FFE},
    '{MODE_PRE_DEC, SIZE_BYTE, 32'h0, 32'h0, 32'hFFFFFF, 32'hFFFFFFFF},
    '{MODE_ABS8, SIZE_BYTE, 32'h34, 32'h0, 32'hFFFF34, 32'h0},
    '{MODE_ABS16, SIZE_BYTE, 32'h8001, 32'h0, 32'hFF8001, 32'h0},
    '{MODE_ABS24, SIZE_BYTE, 32'hABCDEF, 32'h0, 32'hABCDEF, 32'h0},
    '{MODE_IMM8, SIZE_BYTE, 32'hFFFFFF5A, 32'h0, 32'h5A, 32'h0},
    '{MODE_IMM32, SIZE_BYTE, 32'h89ABCDEF, 32'h0, 32'h89ABCDEF, 32'h0},
    '{MODE_IMM16, SIZE_BYTE, 32'h1234ABCD, 32'h0, 32'hABCD, 32'h0},
    '{MODE_IMPLICIT, SIZE_BYTE, 32'h3, 32'h0, 32'hFFFFFFFF, 32'h0},
    '{MODE_BIT_NUMBER, SIZE_BYTE, 32'h5, 32'h0, 32'h5, 32'h0},
    '{MODE_TRAP, SIZE_BYTE, 32'h3, 32'h0, 32'h3, 32'h0},
    '{MODE_PC_REL8, SIZE_BYTE, 32'h80, 32'h1000, 32'hF80, 32'h0},
    '{MODE_PC_REL16, SIZE_BYTE, 32'h8000, 32'h10000, 32'h8000, 32'h0},
    '{MODE_ABS16, SIZE_WORD, 32'h1235, 32'h0, 32'h1234, 32'h0},
    '{MODE_REG_INDIRECT, SIZE_BYTE, 32'h0, 32'hAB123457, 32'h123457, 32'h0},
    '{MODE_DISP16, SIZE_BYTE, 32'hFFF0, 32'h10000, 32'hFFF0, 32'h0}
  };
  always #5 sys_clk = ~sys_clk;
  effective_address_generator u_effective_address_generator (.sys_clk, .rst, .req, .address_register,
    .mode_1mbyte, .ptr_data_valid, .ptr_data, .resp, .branch_target, .branch_target_valid);
  ptr_bus_model u_ptr_bus_model (.sys_clk, .rst, .fetch(resp.ptr_fetch), .slow, .value(ptr_value),
    .data_valid(ptr_data_valid), .data(ptr_data));
  task stop_test;
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held one cycle, checked once settled
  task drive(input row_t r, input logic mb);
    @(posedge sys_clk);
    req <= '{1'b1, r.m, r.s, r.e, r.a[23:0], r.e[2:0], r.m inside {MODE_PC_REL8, MODE_PC_REL16}};
    address_register <= r.a;
    mode_1mbyte <= mb;
    @(negedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    check({8'h0, branch_target}, 32'h0);
    check({31'h0, branch_target_valid}, 32'h0);
    foreach (rows[i]) begin
      drive(rows[i], 1'b0);
      is_op = rows[i].m inside {[MODE_IMM8:MODE_IMM32], [MODE_IMPLICIT:MODE_TRAP]};
      is_wb = rows[i].m inside {MODE_POST_INC, MODE_PRE_DEC};
      check({29'h0, resp.valid, resp.addr_valid, resp.operand_valid}, {29'h0, 1'b1, !is_op, is_op});
      if (is_op)
        check(resp.operand, rows[i].x);
      else
        check({8'h0, resp.addr}, rows[i].x);
      check({31'h0, resp.wb_en}, {31'h0, is_wb});
      if (is_wb)
        check(resp.wb_value, rows[i].w);
    end
    drive(rows[4], 1'b1);
    check({8'h0, resp.addr}, 32'h0FFF34);
    // Prompt and slow pointer answers
    for (int d = 0; d < 2; d++) begin
      slow <= d[0];
      // A new pointer each pass, so a stale target cannot pass
      ptr_value <= d[0] ? 32'h55FEDCBB : 32'hAA123457;
      drive('{MODE_MEM_INDIRECT, SIZE_BYTE, 32'h11, 32'h0, 32'h0, 32'h0}, 1'b0);
      check({8'h0, resp.addr}, 32'h10);
      check({31'h0, resp.ptr_fetch}, 32'h1);
      @(posedge sys_clk);
      req <= '0;
      for (int k = 0; k < 20 && branch_target_valid !== 1'b1; k++) @(negedge sys_clk);
      check({31'h0, branch_target_valid}, 32'h1);
      check({8'h0, branch_target}, d[0] ? 32'h00FEDCBA : 32'h00123456);
      check({7'h0, resp.valid, resp.addr}, 32'h0);
    end
    // Reset in mid-run clears the held target at once
    @(posedge sys_clk);
    rst <= 1'b1;
    @(negedge sys_clk);
    check({7'h0, branch_target_valid, branch_target}, 32'h0);
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    drive(rows[0], 1'b0);
    check({8'h0, resp.addr}, rows[0].x);
    stop_test();
  end
endmodule
bind effective_address_generator ea_gen_sva u_ea_gen_sva (.sys_clk, .rst, .req, .address_register,
  .mode_1mbyte, .ptr_data_valid, .ptr_data, .resp, .branch_target, .branch_target_valid);
